// >>> core/flash_erase_cfg.svh
// constants for the flash block erase sequencer
`ifndef FLASH_ERASE_CFG_SVH
`define FLASH_ERASE_CFG_SVH
// ****************************************
// register byte offsets
// ****************************************
`define OFS_TABLE_POINTER 4'h0
`define OFS_NVM_CONTROL 4'h4
`define OFS_NVM_UNLOCK_PORT 4'h8
`define OFS_ERASE_STATUS 4'hc
// ****************************************
// control field positions
// ****************************************
`define BIT_START 0
`define BIT_PROGRAM_ENABLE 2
`define BIT_ERASE_SEL 4
`define BIT_CONFIG_SPACE_SEL 6
`define BIT_MEMORY_TARGET_SEL 7
// ****************************************
// values and timing
// ****************************************
`define UNLOCK_FIRST 8'h55
`define UNLOCK_SECOND 8'haa
`define PTR_RESET 22'h000000
`define CTRL_RESET 8'h00
`define BLOCK_BYTES 64
`define BLOCK_WORDS 32
`define ERASE_TIME_US 2000
`define CLOCK_MHZ 25
`define ERASE_CYCLES (`ERASE_TIME_US * `CLOCK_MHZ)
`endif

// >>> core/flash_erase_pkg.sv
// types of the flash block erase sequencer
package flash_erase_pkg;
    typedef enum logic [1:0] {
        unlock_idle,
        unlock_half,
        unlock_armed
    } unlock_state_t;
    typedef enum logic [1:0] {
        op_idle,
        op_erase,
        op_write
    } op_state_t;
    typedef struct packed {
        logic valid;
        logic [15:0] block;
    } erase_req_t;
endpackage

// >>> core/flash_block_erase_sequencer.sv
// flash block erase sequencer with avalon-mm register slave
`include "flash_erase_cfg.svh"
module flash_block_erase_sequencer
    import flash_erase_pkg::*;
#(
    parameter int ERASE_CYCLES = `ERASE_CYCLES,
    parameter int WRITE_CYCLES = `ERASE_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic cpu_stall,
    output logic erase_strobe,
    output logic [15:0] erase_block,
    output logic write_strobe,
    output logic [21:0] write_addr
);
    // ****************************************
    // bus handshake
    // ****************************************
    // one wait state: every access answers on the second edge
    logic ack_r;
    logic access;
    assign access = (avs_read | avs_write) & ~ack_r;
    always_ff @(posedge clock) begin
        if (reset) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= access;
        end
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~access;
        end
    end
    logic wr_go;
    logic rd_go;
    assign wr_go = avs_write & ack_r;
    assign rd_go = avs_read & ack_r;
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction
    // ****************************************
    // table pointer and control
    // ****************************************
    logic [21:0] table_pointer_r;
    logic [7:0] ctrl_r;
    op_state_t op_r;
    // last timer count; declared here because the control register clears start on it
    logic op_nxt_done;
    always_ff @(posedge clock) begin
        if (reset) begin
            table_pointer_r <= `PTR_RESET;
        end else if (wr_go && hit(avs_address, `OFS_TABLE_POINTER) && op_r == op_idle) begin
            if (avs_byteenable[0]) begin
                table_pointer_r[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                table_pointer_r[15:8] <= avs_writedata[15:8];
            end
            if (avs_byteenable[2]) begin
                table_pointer_r[21:16] <= avs_writedata[21:16];
            end
        end
    end
    logic start_req;
    assign start_req = wr_go && hit(avs_address, `OFS_NVM_CONTROL) && avs_byteenable[0]
                       && avs_writedata[`BIT_START];
    logic unlocked;
    logic launch;
    logic enabled_nxt;
    assign enabled_nxt = avs_writedata[`BIT_PROGRAM_ENABLE];
    // refused starts still write the other control bits and consume the unlock; program enable is checked as written
    assign launch = start_req && unlocked && enabled_nxt && op_r == op_idle;
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_r <= `CTRL_RESET;
        end else if (wr_go && hit(avs_address, `OFS_NVM_CONTROL) && avs_byteenable[0]) begin
            ctrl_r <= avs_writedata[7:0];
            ctrl_r[`BIT_START] <= launch;
        end else if (op_r != op_idle && op_nxt_done) begin
            ctrl_r[`BIT_START] <= 1'b0;
        end
    end
    // ****************************************
    // unlock sequence
    // ****************************************
    unlock_state_t unlock_r;
    logic unlock_wr;
    assign unlock_wr = wr_go && hit(avs_address, `OFS_NVM_UNLOCK_PORT) && avs_byteenable[0];
    assign unlocked = (unlock_r == unlock_armed);
    always_ff @(posedge clock) begin
        if (reset) begin
            unlock_r <= unlock_idle;
        end else if (unlock_wr) begin
            case (unlock_r)
                unlock_idle: begin
                    unlock_r <= (avs_writedata[7:0] == `UNLOCK_FIRST) ? unlock_half : unlock_idle;
                end
                unlock_half: begin
                    unlock_r <= (avs_writedata[7:0] == `UNLOCK_SECOND) ? unlock_armed
                                                                        : unlock_idle;
                end
                default: begin
                    unlock_r <= unlock_idle;
                end
            endcase
        end else if (wr_go || rd_go) begin
            // the start write itself also consumes the unlock
            unlock_r <= unlock_idle;
        end
    end
    // ****************************************
    // programming timer
    // ****************************************
    logic [31:0] timer_r;
    assign op_nxt_done = (timer_r == 32'h00000001);
    always_ff @(posedge clock) begin
        if (reset) begin
            op_r <= op_idle;
            timer_r <= 32'h00000000;
        end else if (launch) begin
            // erase select picks erase for every target; config space and data targets still run the timer, only their strobe is dropped
            if (avs_writedata[`BIT_ERASE_SEL]) begin
                op_r <= op_erase;
                timer_r <= 32'(ERASE_CYCLES);
            end else begin
                op_r <= op_write;
                timer_r <= 32'(WRITE_CYCLES);
            end
        end else if (op_r != op_idle) begin
            if (op_nxt_done) begin
                op_r <= op_idle;
                timer_r <= 32'h00000000;
            end else begin
                timer_r <= timer_r - 32'h00000001;
            end
        end
    end
    // only flash program memory (target set, config clear) is erased from here
    logic prog_space;
    assign prog_space = avs_writedata[`BIT_MEMORY_TARGET_SEL]
                        & ~avs_writedata[`BIT_CONFIG_SPACE_SEL];
    // ****************************************
    // array-side outputs
    // ****************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            cpu_stall <= 1'b0;
        end else begin
            cpu_stall <= launch | (op_r != op_idle && !op_nxt_done);
        end
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            erase_strobe <= 1'b0;
            erase_block <= 16'h0000;
            write_strobe <= 1'b0;
            write_addr <= 22'h000000;
        end else begin
            // a single one-cycle strobe names one 32-word block; no word or bulk form
            erase_strobe <= launch && avs_writedata[`BIT_ERASE_SEL] && prog_space;
            write_strobe <= launch && !avs_writedata[`BIT_ERASE_SEL] && prog_space;
            if (launch) begin
                erase_block <= table_pointer_r[21:6];
                write_addr <= table_pointer_r;
            end
        end
    end
    // ****************************************
    // read data
    // ****************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            avs_readdata <= 32'h00000000;
        end else if (access && avs_read) begin
            case (avs_address)
                `OFS_TABLE_POINTER: avs_readdata <= {10'h000, table_pointer_r};
                `OFS_NVM_CONTROL: avs_readdata <= {24'h000000, ctrl_r};
                `OFS_ERASE_STATUS: avs_readdata <= {28'h0000000, unlock_r == unlock_armed,
                                                    unlock_r == unlock_half,
                                                    op_r == op_write, op_r == op_erase};
                default: avs_readdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// >>> tb/flash_erase_checker.sv
// assertions on the ports of the flash block erase sequencer
// ****************************************
// checker
// ****************************************
module flash_erase_checker
    import flash_erase_pkg::*;
#(
    parameter int ERASE_CYCLES = 20
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic cpu_stall,
    input wire logic erase_strobe
);
    logic [31:0] run_r;
    // counts stall cycles so long waits need no long repetition
    always_ff @(posedge clock) begin
        if (reset || !cpu_stall) begin
            run_r <= '0;
        end else begin
            run_r <= run_r + 1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_start;
        avs_write && !avs_waitrequest && avs_address == 4'h4 && avs_writedata[0];
    endsequence
    property p_wait_once; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_wait_once: assert property (p_wait_once) else $error("wait low too long");
    property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("no answer after one wait");
    property p_pulse; erase_strobe |=> !erase_strobe; endproperty
    a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
    property p_in_stall; erase_strobe |-> $rose(cpu_stall); endproperty
    a_in_stall: assert property (p_in_stall) else $error("strobe outside stall start");
    property p_cause; $rose(cpu_stall) |-> $past(avs_write && !avs_waitrequest && avs_writedata[0]); endproperty
    a_cause: assert property (p_cause) else $error("stall without start");
    property p_len; $fell(cpu_stall) |-> run_r == ERASE_CYCLES; endproperty
    a_len: assert property (p_len) else $error("stall length wrong");
    property p_end; cpu_stall && run_r == ERASE_CYCLES - 1 |=> !cpu_stall; endproperty
    a_end: assert property (p_end) else $error("stall not ended by timer");
    property p_no_enable; (s_start and !avs_writedata[2] && !cpu_stall) |=> !cpu_stall; endproperty
    a_no_enable: assert property (p_no_enable) else $error("start without enable ran");
endmodule
bind flash_block_erase_sequencer flash_erase_checker #(.ERASE_CYCLES(ERASE_CYCLES)) chk_i (
    .clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .cpu_stall(cpu_stall), .erase_strobe(erase_strobe));

// >>> tb/flash_block_erase_sequencer_tb_top.sv
// self-checking testbench of the flash block erase sequencer
// ****************************************
// bench
// ****************************************
module flash_block_erase_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int ERC = 20;
    logic clock = 0, reset = 1, avs_read = 0, avs_write = 0, avs_waitrequest, cpu_stall;
    logic [3:0] avs_address = 0, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 0, avs_readdata;
    logic erase_strobe;
    logic [15:0] erase_block, blk;
    int num_errors = 0, checked = 0, nstrobe = 0, nstall = 0;
    flash_block_erase_sequencer #(.ERASE_CYCLES(ERC), .WRITE_CYCLES(ERC)) uut (
        .clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_stall(cpu_stall),
        .erase_strobe(erase_strobe), .erase_block(erase_block), .write_strobe(),
        .write_addr());
    always #20 clock = ~clock;
    always @(posedge clock) begin
        if (erase_strobe === 1'b1) begin
            nstrobe++;
            blk = erase_block;
        end
        if (cpu_stall === 1'b1) nstall++;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // holds the request until waitrequest is sampled low
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clock);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task automatic t_reset_vals();
        logic [31:0] q;
        bus(4'h2, 1, 32'hffffffff, q);
        bus(4'h2, 0, 0, q);
        chk(q, 0);
        bus(4'h0, 0, 0, q);
        chk(q, 0);
        bus(4'h4, 0, 0, q);
        chk(q, 0);
    endtask
    // full sequence; mid puts a status read inside the unlock
    task automatic t_erase(input logic [21:0] p, input logic [7:0] c, input logic [7:0] u1,
                           input logic mid, input logic ok, input logic stl);
        logic [31:0] q;
        bus(4'h0, 1, {10'h0, p}, q);
        bus(4'h4, 1, {24'h0, c & 8'hfe}, q);
        // apart from the mid status read, no access of any kind falls between the unlock writes and the start
        bus(4'h8, 1, {24'h0, u1}, q);
        if (mid) bus(4'hc, 0, 0, q);
        bus(4'h8, 1, 32'h000000aa, q);
        nstrobe = 0;
        nstall = 0;
        bus(4'h4, 1, {24'h0, c}, q);
        // the stall length is fixed by the timer, so a fixed wait is enough
        repeat (ERC + 4) @(posedge clock);
        chk(nstrobe, {31'h0, ok});
        chk(nstall, stl ? ERC : 0);
        if (ok) chk({16'h0, blk}, {16'h0, p[21:6]});
        bus(4'h4, 0, 0, q);
        chk(q, {24'h0, c & 8'hfe});
    endtask
    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock);
        reset <= 0;
        t_reset_vals();
        t_erase(22'h2a5c3f, 8'h95, 8'h55, 0, 1, 1);
        t_erase(22'h3fffff, 8'h95, 8'h55, 0, 1, 1);
        t_erase(22'h001040, 8'h91, 8'h55, 0, 0, 0);
        t_erase(22'h001040, 8'h95, 8'haa, 0, 0, 0);
        t_erase(22'h001040, 8'h95, 8'h55, 1, 0, 0);
        t_erase(22'h001040, 8'h85, 8'h55, 0, 0, 1);
        t_erase(22'h001040, 8'hd5, 8'h55, 0, 0, 1);
        t_erase(22'h001040, 8'h15, 8'h55, 0, 0, 1);
        report_and_stop();
    end
    initial begin
        repeat (2000) @(posedge clock);
        num_errors++;
        report_and_stop();
    end
endmodule
